/* core/copro_access_pkg.sv */
// Purpose: constants for the coprocessor access permission block
// Assumes: single clock, system-control register access port
// Notes:   field positions, reset values and register selectors
// Overview of operation
// - access control register: one shared read/write register, privileged only, resets to zero
// - simd_disable bit 31 set disables pure vector SIMD instructions
// - upper_bank_disable bit 30 set disables float instructions touching upper_double_regs
// - permission field: 00 denied, 01 privileged only, 10 reserved, 11 all
// - copro eleven field bits 23:22, copro ten bits 21:20, reset denied
// - user mode access to the permission registers raises undefined instruction
// - secure privileged always; nonsecure privileged only if ns bits set, else zero/ignored
// - register updates take effect only after the next sync barrier
// - access control register selected by crn c1, op1 0, crm c0, op2 2
// - nonsecure register: secure read/write, nonsecure read-only, privileged only
// - nonsecure use of coprocessors also needs nonsecure register permission
// - ns bits 11 and 10: 0 secure only (reset), 1 secure or nonsecure
// - ns bit 15 forces simd_disable to read 1 and ignore nonsecure writes
// - ns bit 14 forces upper_bank_disable to read 1 and ignore nonsecure writes
// - nonsecure register selected by crn c1, op1 0, crm c1, op2 2
package copro_access_pkg;
  localparam logic [3:0]  SEL_CRN         = 4'h1;
  localparam logic [2:0]  SEL_OP1         = 3'h0;
  localparam logic [3:0]  SEL_CRM_ACCESS  = 4'h0;
  localparam logic [3:0]  SEL_CRM_NS      = 4'h1;
  localparam logic [2:0]  SEL_OP2         = 3'h2;
  localparam int          BIT_SIMD_DIS    = 31;
  localparam int          BIT_UPPER_DIS   = 30;
  localparam int          POS_ELEVEN      = 22;
  localparam int          POS_TEN         = 20;
  localparam int          BIT_NS_SIMD     = 15;
  localparam int          BIT_NS_UPPER    = 14;
  localparam int          BIT_NS_ELEVEN   = 11;
  localparam int          BIT_NS_TEN      = 10;
  localparam logic [31:0] ACCESS_RESET    = 32'h0000_0000;
  localparam logic [31:0] NS_RESET        = 32'h0000_0000;
  // implemented bits; all others read zero and ignore writes
  localparam logic [31:0] ACCESS_MASK     = 32'hC0F0_0000;
  localparam logic [31:0] NS_MASK         = 32'h0000_CC00;
  localparam logic [1:0]  PERM_DENIED     = 2'h0;
  localparam logic [1:0]  PERM_PRIV       = 2'h1;
  localparam logic [1:0]  PERM_ALL        = 2'h3;
endpackage

/* core/copro_perm_check.sv */
// Purpose: decode one two-bit permission field for one coprocessor
// Assumes: combinational, used once per coprocessor
// Notes:   reserved code 10 is treated as denied
`timescale 1ns/10ps
module copro_perm_check
  import copro_access_pkg::*;
(
  input  wire logic [1:0] perm_i,
  input  wire logic       ns_grant_i,
  input  wire logic       secure_i,
  input  wire logic       priv_i,
  output logic            allow_o
);
  always_comb begin
    case (perm_i)
      PERM_PRIV: allow_o = priv_i;
      PERM_ALL:  allow_o = 1'b1;
      default:   allow_o = 1'b0;
    endcase
    if (!secure_i && !ns_grant_i) begin
      allow_o = 1'b0;
    end
  end
endmodule // copro_perm_check

/* core/coproc_access_permission_ctrl.sv */
// Purpose: coprocessor access control and nonsecure access control registers, plus check
// Assumes: core presents one system-register access or coprocessor instruction per cycle
// Notes:   settings reach the check only at sync_barrier_i; reads return a registered value
`timescale 1ns/10ps
module coproc_access_permission_ctrl
  import copro_access_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        secure_i,
  input  wire logic        priv_i,
  input  wire logic        sys_valid_i,
  input  wire logic        sys_write_i,
  input  wire logic [3:0]  sys_crn_i,
  input  wire logic [2:0]  sys_op1_i,
  input  wire logic [3:0]  sys_crm_i,
  input  wire logic [2:0]  sys_op2_i,
  input  wire logic [31:0] sys_wdata_i,
  input  wire logic        sync_barrier_i,
  input  wire logic        instr_valid_i,
  input  wire logic        instr_copro_eleven_i,
  input  wire logic        instr_simd_only_i,
  input  wire logic        instr_upper_regs_i,
  output logic [31:0]      sys_rdata_o,
  output logic             sys_rvalid_o,
  output logic             undef_o,
  output logic [31:0]      copro_access_ctrl_o,
  output logic [31:0]      nonsecure_access_ctrl_o
);
  typedef struct packed {
    logic [31:0] access;
    logic [31:0] ns;
    logic [31:0] eff_access;
    logic [31:0] eff_ns;
    logic [31:0] rdata;
    logic        rvalid;
    logic        undef;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic   allow_ten;
  logic   allow_eleven;
  logic   hit_access;
  logic   hit_ns;
  logic   ns_ten;
  logic   ns_eleven;
  logic   ns_simd;
  logic   ns_upper;

  // permission check runs on the barrier-committed copy, never the live one
  copro_perm_check u_ten (
    .perm_i     (state_reg.eff_access[POS_TEN +: 2]),
    .ns_grant_i (state_reg.eff_ns[BIT_NS_TEN]),
    .secure_i   (secure_i),
    .priv_i     (priv_i),
    .allow_o    (allow_ten)
  );
  copro_perm_check u_eleven (
    .perm_i     (state_reg.eff_access[POS_ELEVEN +: 2]),
    .ns_grant_i (state_reg.eff_ns[BIT_NS_ELEVEN]),
    .secure_i   (secure_i),
    .priv_i     (priv_i),
    .allow_o    (allow_eleven)
  );

  always_comb begin
    state_next = state_reg;
    hit_access = (sys_crn_i == SEL_CRN) && (sys_op1_i == SEL_OP1) &&
                 (sys_crm_i == SEL_CRM_ACCESS) && (sys_op2_i == SEL_OP2);
    hit_ns     = (sys_crn_i == SEL_CRN) && (sys_op1_i == SEL_OP1) &&
                 (sys_crm_i == SEL_CRM_NS) && (sys_op2_i == SEL_OP2);
    ns_ten     = state_reg.ns[BIT_NS_TEN];
    ns_eleven  = state_reg.ns[BIT_NS_ELEVEN];
    ns_simd    = state_reg.ns[BIT_NS_SIMD];
    ns_upper   = state_reg.ns[BIT_NS_UPPER];
    state_next.rvalid = 1'b0;
    state_next.undef  = 1'b0;
    if (sys_valid_i && (hit_access || hit_ns)) begin
      if (!priv_i) begin
        state_next.undef = 1'b1;
      end else if (hit_access) begin
        if (sys_write_i) begin
          if (secure_i || ns_ten) begin
            state_next.access[POS_TEN +: 2] = sys_wdata_i[POS_TEN +: 2];
          end
          if (secure_i || ns_eleven) begin
            state_next.access[POS_ELEVEN +: 2] = sys_wdata_i[POS_ELEVEN +: 2];
          end
          if (secure_i || !ns_simd) begin
            state_next.access[BIT_SIMD_DIS] = sys_wdata_i[BIT_SIMD_DIS];
          end
          if (secure_i || !ns_upper) begin
            state_next.access[BIT_UPPER_DIS] = sys_wdata_i[BIT_UPPER_DIS];
          end
        end else begin
          state_next.rvalid = 1'b1;
          state_next.rdata  = state_reg.access & ACCESS_MASK;
          if (!secure_i) begin
            if (!ns_ten) begin
              state_next.rdata[POS_TEN +: 2] = 2'h0;
            end
            if (!ns_eleven) begin
              state_next.rdata[POS_ELEVEN +: 2] = 2'h0;
            end
            if (ns_simd) begin
              state_next.rdata[BIT_SIMD_DIS] = 1'b1;
            end
            if (ns_upper) begin
              state_next.rdata[BIT_UPPER_DIS] = 1'b1;
            end
          end
        end
      end else begin
        if (sys_write_i) begin
          if (secure_i) begin
            state_next.ns = sys_wdata_i & NS_MASK;
          end else begin
            state_next.undef = 1'b1;
          end
        end else begin
          state_next.rvalid = 1'b1;
          state_next.rdata  = state_reg.ns & NS_MASK;
        end
      end
    end
    if (sync_barrier_i) begin
      state_next.eff_access = state_reg.access;
      state_next.eff_ns     = state_reg.ns;
    end
    if (instr_valid_i) begin
      if (!(instr_copro_eleven_i ? allow_eleven : allow_ten)) begin
        state_next.undef = 1'b1;
      end
      if (instr_simd_only_i && state_reg.eff_access[BIT_SIMD_DIS]) begin
        state_next.undef = 1'b1;
      end
      if (instr_upper_regs_i && state_reg.eff_access[BIT_UPPER_DIS]) begin
        state_next.undef = 1'b1;
      end
      // nonsecure forces apply even if the stored disable is clear
      if (!secure_i && instr_simd_only_i && state_reg.eff_ns[BIT_NS_SIMD]) begin
        state_next.undef = 1'b1;
      end
      if (!secure_i && instr_upper_regs_i && state_reg.eff_ns[BIT_NS_UPPER]) begin
        state_next.undef = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg            <= '0;
      state_reg.access     <= ACCESS_RESET;
      state_reg.ns         <= NS_RESET;
      state_reg.eff_access <= ACCESS_RESET;
      state_reg.eff_ns     <= NS_RESET;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign sys_rdata_o             = state_reg.rdata;
  assign sys_rvalid_o            = state_reg.rvalid;
  assign undef_o                 = state_reg.undef;
  assign copro_access_ctrl_o     = state_reg.access;
  assign nonsecure_access_ctrl_o = state_reg.ns;

  property p_user_refused;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && !priv_i && hit_access) |=> undef_o;
  endproperty
  a_user_refused: assert property (p_user_refused) else $error("user access not refused");

  property p_ns_write_ignored;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && sys_write_i && hit_access && priv_i && !secure_i && !ns_ten)
      |=> $stable(copro_access_ctrl_o[POS_TEN +: 2]);
  endproperty
  a_ns_write_ignored: assert property (p_ns_write_ignored) else $error("ns write took");

  property p_ns_read_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && !sys_write_i && hit_access && priv_i && !secure_i && !ns_eleven)
      |=> sys_rvalid_o && (sys_rdata_o[POS_ELEVEN +: 2] == 2'h0);
  endproperty
  a_ns_read_zero: assert property (p_ns_read_zero) else $error("ns read not zero");

  property p_ns_reg_readonly;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && sys_write_i && hit_ns && priv_i && !secure_i)
      |=> undef_o && $stable(nonsecure_access_ctrl_o);
  endproperty
  a_ns_reg_readonly: assert property (p_ns_reg_readonly) else $error("ns reg written");

  property p_simd_force_read;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && !sys_write_i && hit_access && priv_i && !secure_i && ns_simd)
      |=> sys_rdata_o[BIT_SIMD_DIS];
  endproperty
  a_simd_force_read: assert property (p_simd_force_read) else $error("simd force lost");

  property p_upper_force_write;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && sys_valid_i && sys_write_i && hit_access && priv_i && !secure_i && ns_upper)
      |=> $stable(copro_access_ctrl_o[BIT_UPPER_DIS]);
  endproperty
  a_upper_force_write: assert property (p_upper_force_write) else $error("upper written");

  property p_simd_disable;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && instr_valid_i && instr_simd_only_i && state_reg.eff_access[BIT_SIMD_DIS])
      |=> undef_o;
  endproperty
  a_simd_disable: assert property (p_simd_disable) else $error("simd not disabled");

  property p_upper_disable;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && instr_valid_i && instr_upper_regs_i && state_reg.eff_access[BIT_UPPER_DIS])
      |=> undef_o;
  endproperty
  a_upper_disable: assert property (p_upper_disable) else $error("upper not disabled");

  property p_denied;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && instr_valid_i && !instr_copro_eleven_i &&
       state_reg.eff_access[POS_TEN +: 2] == PERM_DENIED)
      |=> undef_o;
  endproperty
  a_denied: assert property (p_denied) else $error("denied access passed");

  property p_barrier;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && !sync_barrier_i) |=> $stable(state_reg.eff_access);
  endproperty
  a_barrier: assert property (p_barrier) else $error("settings moved without barrier");
endmodule // coproc_access_permission_ctrl

/* sim/core_model.sv */
// Purpose: core-side model issuing register accesses, barriers and coprocessor instructions
// Assumes: drives at the falling edge, one request per call
// Notes:   released wdata and instr lines show the inverse of the last data; valid and barrier strobes drop to zero, other lines keep their last value
`timescale 1ns/10ps
module core_model
  import copro_access_pkg::*;
(
  input  wire logic        clk_i,
  output logic             secure_o,
  output logic             priv_o,
  output logic             sys_valid_o,
  output logic             sys_write_o,
  output logic [3:0]       sys_crn_o,
  output logic [2:0]       sys_op1_o,
  output logic [3:0]       sys_crm_o,
  output logic [2:0]       sys_op2_o,
  output logic [31:0]      sys_wdata_o,
  output logic             sync_barrier_o,
  output logic             instr_valid_o,
  output logic [2:0]       instr_o
);
  initial begin
    {secure_o, priv_o, sys_valid_o, sys_write_o, sync_barrier_o, instr_valid_o} = 6'h00;
    {sys_crn_o, sys_op1_o, sys_crm_o, sys_op2_o, sys_wdata_o, instr_o} = '0;
  end
  // kind: 0/1 read/write access reg, 2/3 read/write ns reg, 4 barrier, 5 instr, 6 stray
  task automatic issue(input int kind, input logic sec, input logic pri,
                       input logic [31:0] wd, input logic [2:0] ins);
    @(negedge clk_i);
    secure_o = sec;
    priv_o = pri;
    sys_valid_o = (kind <= 3) || (kind == 6);
    sys_write_o = kind[0];
    sys_crn_o = SEL_CRN;
    sys_op1_o = SEL_OP1;
    sys_op2_o = SEL_OP2;
    sys_crm_o = (kind == 6) ? 4'h2 : ((kind >= 2) ? SEL_CRM_NS : SEL_CRM_ACCESS);
    sys_wdata_o = wd;
    sync_barrier_o = (kind == 4);
    instr_valid_o = (kind == 5);
    instr_o = ins;
    @(negedge clk_i);
    sys_valid_o = 1'b0;
    sync_barrier_o = 1'b0;
    instr_valid_o = 1'b0;
    sys_wdata_o = ~wd;
    instr_o = ~ins;
  endtask
endmodule // core_model

/* sim/coproc_access_permission_ctrl_test.sv */
// Purpose: self-checking bench for the coprocessor access permission block
// Assumes: 125 MHz clock, reference model updated per request
// Notes:   answers are checked one cycle after the request edge
`timescale 1ns/10ps
module coproc_access_permission_ctrl_test;
  import copro_access_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, ce = 1'b1, sec, pri, sv, sw, sb, iv, undef_o, sys_rvalid_o;
  logic [3:0] crn, crm;
  logic [2:0] op1, op2, ins;
  logic [31:0] wd, sys_rdata_o, acc_o, ns_o, acc, ns, eacc, ens;
  int n_fail = 0, comparisons = 0;
  always #4 clk_i = ~clk_i;
  core_model u_core (.clk_i(clk_i), .secure_o(sec), .priv_o(pri), .sys_valid_o(sv),
    .sys_write_o(sw), .sys_crn_o(crn), .sys_op1_o(op1), .sys_crm_o(crm), .sys_op2_o(op2),
    .sys_wdata_o(wd), .sync_barrier_o(sb), .instr_valid_o(iv), .instr_o(ins));
  coproc_access_permission_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .secure_i(sec), .priv_i(pri), .sys_valid_i(sv), .sys_write_i(sw), .sys_crn_i(crn),
    .sys_op1_i(op1), .sys_crm_i(crm), .sys_op2_i(op2), .sys_wdata_i(wd),
    .sync_barrier_i(sb), .instr_valid_i(iv), .instr_copro_eleven_i(ins[2]),
    .instr_simd_only_i(ins[1]), .instr_upper_regs_i(ins[0]), .sys_rdata_o(sys_rdata_o),
    .sys_rvalid_o(sys_rvalid_o), .undef_o(undef_o), .copro_access_ctrl_o(acc_o),
    .nonsecure_access_ctrl_o(ns_o));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input int kind, input logic s, input logic p, input logic [31:0] d,
                     input logic [2:0] i);
    logic [31:0] view, nv, rd;
    logic [1:0] pm;
    logic eu, erv;
    eu = 1'b0;
    erv = 1'b0;
    rd = '0;
    view = acc;
    nv = d & ACCESS_MASK;
    if (!s) begin
      if (!ns[11]) {view[23:22], nv[23:22]} = {2'h0, acc[23:22]};
      if (!ns[10]) {view[21:20], nv[21:20]} = {2'h0, acc[21:20]};
      if (ns[15]) {view[31], nv[31]} = {1'b1, acc[31]};
      if (ns[14]) {view[30], nv[30]} = {1'b1, acc[30]};
    end
    u_core.issue(kind, s, p, d, i);
    if (kind <= 3 && (!p || (kind == 3 && !s))) eu = 1'b1;
    else if (kind == 0) {erv, rd} = {1'b1, view};
    else if (kind == 1) acc = nv;
    else if (kind == 2) {erv, rd} = {1'b1, ns};
    else if (kind == 3) ns = d & NS_MASK;
    else if (kind == 4) {eacc, ens} = {acc, ns};
    else if (kind == 5) begin
      pm = i[2] ? eacc[23:22] : eacc[21:20];
      eu = !(s || (i[2] ? ens[11] : ens[10])) || !(pm == PERM_ALL || (pm == PERM_PRIV && p));
      eu = eu || (i[1] && (eacc[31] || (!s && ens[15])));
      eu = eu || (i[0] && (eacc[30] || (!s && ens[14])));
    end
    check("undef", {31'h0, undef_o}, {31'h0, eu});
    check("rvalid", {31'h0, sys_rvalid_o}, {31'h0, erv});
    if (erv) check("rdata", sys_rdata_o, rd);
    check("access reg", acc_o, acc);
    check("ns reg", ns_o, ns);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {acc, ns, eacc, ens} = '0;
    void'($urandom(32'hBDEA));
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    check("access reset", acc_o, ACCESS_RESET);
    check("ns reset", ns_o, NS_RESET);
    run(5, 1'b1, 1'b1, 32'h0, 3'h4);
    $display("test reset done");
    // enable both coprocessors by read, modify, write, then barrier and use
    run(0, 1'b1, 1'b1, 32'h0, 3'h0);
    run(5, 1'b1, 1'b1, 32'h0, 3'h0);
    run(1, 1'b1, 1'b1, acc | 32'h00F0_0000, 3'h0);
    run(5, 1'b1, 1'b1, 32'h0, 3'h0);
    run(4, 1'b1, 1'b1, 32'h0, 3'h0);
    for (int k = 0; k < 8; k++) run(5, k[0], k[1], 32'h0, k[2:0]);
    $display("test enable done");
    for (int k = 0; k < 600; k++) run($urandom % 7, ($urandom % 4) != 0, ($urandom % 4) != 0,
                                      $urandom, 3'($urandom));
    $display("test random done");
    // let the last answer clear first, so the frozen outputs are known to be idle
    @(negedge clk_i);
    ce = 1'b0;
    u_core.issue(1, 1'b1, 1'b1, 32'hFFFF_FFFF, 3'h0);
    check("frozen access reg", acc_o, acc);
    check("frozen undef", {31'h0, undef_o}, 32'h0);
    check("frozen rvalid", {31'h0, sys_rvalid_o}, 32'h0);
    ce = 1'b1;
    $display("test freeze done");
    finish_test();
  end
endmodule // coproc_access_permission_ctrl_test
